// ---- core/spsig_defines.vh ----
// Shared constants of the secondary bus signalling block
`ifndef SPSIG_DEFINES_VH
`define SPSIG_DEFINES_VH

`define SPSIG_AD_W 32
`define SPSIG_CBE_W 4
`define SPSIG_CMD_DUAL 4'hd
`define SPSIG_PARK_AD 32'h00000000
`define SPSIG_PARK_CBE 4'h0
`define SPSIG_AD_RST 32'h00000000
`define SPSIG_CBE_RST 4'hf
`define SPSIG_BE_RST 4'hf
`define SPSIG_DEASSERT 1'b1
`define SPSIG_ASSERT 1'b0

`endif

// ---- core/spsig_par_unit.v ----
// Even parity generator and receive checker for the secondary bus
`timescale 1ns/1ps
`include "spsig_defines.vh"

module spsig_par_unit (
    input wire ref_clk, // System clock
    input wire reset, // Synchronous reset, active high
    input wire [`SPSIG_AD_W-1:0] gen_ad, // Registered address/data being driven
    input wire [`SPSIG_CBE_W-1:0] gen_cbe, // Command/byte enables on the bus this cycle
    input wire gen_oe, // Address/data lines driven by us this cycle
    input wire [`SPSIG_AD_W-1:0] rx_ad, // Sampled address/data lines
    input wire [`SPSIG_CBE_W-1:0] rx_cbe, // Sampled command/byte-enable lines
    input wire rx_par, // Sampled parity line
    input wire rx_valid, // Sampled bits form a valid phase from another agent
    output reg par_out, // Parity drive value
    output reg par_oe, // Parity drive enable
    output reg par_err // One-cycle pulse on a parity mismatch
);

    reg chk_pend;
    reg chk_par;

    // ---------------------------------------------------------------
    // Generation, one clock behind the covered bits
    // ---------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            par_out <= 1'b0;
            par_oe <= 1'b0;
        end
        else
        begin
            par_out <= ^{gen_ad, gen_cbe};
            par_oe <= gen_oe;
        end
    end

    // ---------------------------------------------------------------
    // Checking of received phases
    // ---------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            chk_pend <= 1'b0;
            chk_par <= 1'b0;
            par_err <= 1'b0;
        end
        else
        begin
            chk_pend <= rx_valid;
            chk_par <= ^{rx_ad, rx_cbe};
            par_err <= chk_pend & (chk_par != rx_par);
        end
    end

endmodule

// ---- core/spsig_sec_bus.v ----
// Secondary bus signalling: initiator sequencing, parking and parity
`timescale 1ns/1ps
`include "spsig_defines.vh"

module spsig_sec_bus (
    input wire ref_clk, // System clock, 50 MHz
    input wire reset, // Synchronous reset, active high
    input wire s_gnt_l, // Bridge secondary grant, active low
    input wire [`SPSIG_AD_W-1:0] s_ad_in, // Address/data pin level
    output reg [`SPSIG_AD_W-1:0] s_ad_out, // Address/data drive value
    output reg s_ad_oe, // Address/data drive enable
    input wire [`SPSIG_CBE_W-1:0] s_cbe_l_in, // Command/byte-enable pin level
    output reg [`SPSIG_CBE_W-1:0] s_cbe_l_out, // Command/byte-enable drive value
    output reg s_cbe_oe, // Command/byte-enable drive enable
    input wire s_par_in, // Parity pin level
    output wire s_par_out, // Parity drive value
    output wire s_par_oe, // Parity drive enable
    input wire s_frame_l_in, // Frame pin level
    output reg s_frame_l_out, // Frame drive value
    output reg s_frame_oe, // Frame drive enable
    input wire s_irdy_l_in, // Initiator ready pin level
    output reg s_irdy_l_out, // Initiator ready drive value
    output reg s_irdy_oe, // Initiator ready drive enable
    input wire s_trdy_l_in, // Target ready pin level
    input wire req_start, // Request a transaction, level until req_ack
    input wire [`SPSIG_CBE_W-1:0] req_cmd, // Transaction command
    input wire req_dual, // Use two address phases
    input wire [`SPSIG_AD_W-1:0] req_addr, // Address, low word
    input wire [`SPSIG_AD_W-1:0] req_addr_hi, // Address, high word for dual
    input wire req_write, // Transaction is a write
    output reg req_ack, // Pulse: request taken
    input wire dat_valid, // Write data ready, or room for read data
    input wire [`SPSIG_AD_W-1:0] dat_wr, // Write data
    input wire [`SPSIG_CBE_W-1:0] dat_be_l, // Byte enables, active low
    input wire dat_last, // This data phase is the last
    output reg dat_ack, // Pulse: data phase inputs taken
    output reg [`SPSIG_AD_W-1:0] rd_data, // Read data captured
    output reg rd_valid, // Pulse: rd_data is new
    output reg xfer_done, // Pulse: transaction ended
    input wire tgt_drive, // Bridge as target drives read data
    input wire [`SPSIG_AD_W-1:0] tgt_data, // Target read data
    output reg busy, // Bridge owns a transaction
    output wire par_err // Pulse: received parity mismatch
);

    localparam ST_IDLE = 3'b000;
    localparam ST_ADDR = 3'b001;
    localparam ST_ADDR2 = 3'b010;
    localparam ST_DATA = 3'b011;
    localparam ST_TURN = 3'b100;

    reg [2:0] state;
    reg [2:0] next_state;
    reg wr_mode;
    reg dual_mode;
    reg [`SPSIG_AD_W-1:0] addr_hi;
    reg [`SPSIG_CBE_W-1:0] cmd;
    reg frame_prev;
    reg [`SPSIG_AD_W-1:0] next_ad;
    reg next_ad_oe;
    reg [`SPSIG_CBE_W-1:0] next_cbe;
    reg next_cbe_oe;
    reg next_frame;
    reg next_frame_oe;
    reg next_irdy;
    reg next_irdy_oe;
    reg next_req_ack;
    reg next_dat_ack;
    reg next_done;
    wire bus_idle;
    wire phase_done;
    wire [`SPSIG_CBE_W-1:0] bus_cbe;
    wire rx_valid;

    assign bus_idle = s_frame_l_in & s_irdy_l_in;
    // Completion uses our own registered IRDY together with the sampled TRDY
    assign phase_done = ~s_irdy_l_out & s_irdy_oe & ~s_trdy_l_in;
    // When another agent owns the byte enables, parity must cover what it drives
    assign bus_cbe = s_cbe_oe ? s_cbe_l_out : s_cbe_l_in;
    // Address edge or completed data phase that we did not drive
    assign rx_valid = ~s_ad_oe & ((~s_frame_l_in & frame_prev) | (~s_irdy_l_in & ~s_trdy_l_in));

    // ---------------------------------------------------------------
    // Next-state and pin decode
    // ---------------------------------------------------------------
    always @*
    begin
        next_state = state;
        next_ad = s_ad_out;
        next_ad_oe = s_ad_oe;
        next_cbe = s_cbe_l_out;
        next_cbe_oe = s_cbe_oe;
        next_frame = s_frame_l_out;
        next_frame_oe = s_frame_oe;
        next_irdy = s_irdy_l_out;
        next_irdy_oe = s_irdy_oe;
        next_req_ack = 1'b0;
        next_dat_ack = 1'b0;
        next_done = 1'b0;
        case (state)
            ST_IDLE:
            begin
                next_frame_oe = 1'b0;
                next_irdy_oe = 1'b0;
                if (req_start && !s_gnt_l && bus_idle)
                begin
                    next_state = ST_ADDR;
                    next_req_ack = 1'b1;
                    next_ad = req_addr;
                    next_ad_oe = 1'b1;
                    next_cbe = req_dual ? `SPSIG_CMD_DUAL : req_cmd;
                    next_cbe_oe = 1'b1;
                    next_frame = `SPSIG_ASSERT;
                    next_frame_oe = 1'b1;
                    next_irdy = `SPSIG_DEASSERT;
                    next_irdy_oe = 1'b1;
                end
                else if (tgt_drive)
                begin
                    next_ad = tgt_data;
                    next_ad_oe = 1'b1;
                    next_cbe_oe = 1'b0;
                end
                else if (!s_gnt_l && bus_idle)
                begin
                    next_ad = `SPSIG_PARK_AD;
                    next_ad_oe = 1'b1;
                    next_cbe = `SPSIG_PARK_CBE;
                    next_cbe_oe = 1'b1;
                end
                else
                begin
                    next_ad_oe = 1'b0;
                    next_cbe_oe = 1'b0;
                end
            end
            ST_ADDR:
            begin
                if (dual_mode)
                begin
                    next_state = ST_ADDR2;
                    next_ad = addr_hi;
                    next_cbe = cmd;
                end
                else
                begin
                    next_state = ST_DATA;
                    next_ad_oe = wr_mode; // Read turnaround leaves the lines to the target
                    next_cbe = `SPSIG_BE_RST;
                end
            end
            ST_ADDR2:
            begin
                next_state = ST_DATA;
                next_ad_oe = wr_mode;
                next_cbe = `SPSIG_BE_RST;
            end
            ST_DATA:
            begin
                if (phase_done)
                begin
                    // Input for the next phase is taken only a clock later, so dat_ack is seen first
                    next_irdy = `SPSIG_DEASSERT;
                    if (s_frame_l_out == `SPSIG_DEASSERT)
                    begin
                        next_state = ST_TURN;
                        next_done = 1'b1;
                        next_ad_oe = 1'b0;
                        next_cbe_oe = 1'b0;
                        next_frame_oe = 1'b1;
                    end
                end
                else if (s_irdy_l_out == `SPSIG_DEASSERT && dat_valid)
                begin
                    next_irdy = `SPSIG_ASSERT;
                    next_dat_ack = 1'b1;
                    next_cbe = dat_be_l;
                    if (wr_mode)
                    begin
                        next_ad = dat_wr;
                    end
                    next_frame = dat_last ? `SPSIG_DEASSERT : `SPSIG_ASSERT;
                end
                // Otherwise IRDY holds its value until completion
            end
            ST_TURN:
            begin
                next_state = ST_IDLE;
                next_frame_oe = 1'b0;
                next_irdy_oe = 1'b0;
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            state <= ST_IDLE;
            wr_mode <= 1'b0;
            dual_mode <= 1'b0;
            addr_hi <= `SPSIG_AD_RST;
            cmd <= `SPSIG_CBE_RST;
            frame_prev <= `SPSIG_DEASSERT;
            s_ad_out <= `SPSIG_AD_RST;
            s_ad_oe <= 1'b0;
            s_cbe_l_out <= `SPSIG_CBE_RST;
            s_cbe_oe <= 1'b0;
            s_frame_l_out <= `SPSIG_DEASSERT;
            s_frame_oe <= 1'b0;
            s_irdy_l_out <= `SPSIG_DEASSERT;
            s_irdy_oe <= 1'b0;
            req_ack <= 1'b0;
            dat_ack <= 1'b0;
            rd_data <= `SPSIG_AD_RST;
            rd_valid <= 1'b0;
            xfer_done <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            state <= next_state;
            frame_prev <= s_frame_l_in;
            if (next_req_ack)
            begin
                wr_mode <= req_write;
                dual_mode <= req_dual;
                addr_hi <= req_addr_hi;
                cmd <= req_cmd;
            end
            s_ad_out <= next_ad;
            s_ad_oe <= next_ad_oe;
            s_cbe_l_out <= next_cbe;
            s_cbe_oe <= next_cbe_oe;
            s_frame_l_out <= next_frame;
            s_frame_oe <= next_frame_oe;
            s_irdy_l_out <= next_irdy;
            s_irdy_oe <= next_irdy_oe;
            req_ack <= next_req_ack;
            dat_ack <= next_dat_ack;
            xfer_done <= next_done;
            rd_valid <= phase_done & ~wr_mode;
            if (phase_done && !wr_mode)
            begin
                rd_data <= s_ad_in;
            end
            busy <= (next_state != ST_IDLE);
        end
    end

    // ---------------------------------------------------------------
    // Parity
    // ---------------------------------------------------------------
    spsig_par_unit u_par (
        .ref_clk(ref_clk),
        .reset(reset),
        .gen_ad(s_ad_out),
        .gen_cbe(bus_cbe),
        .gen_oe(s_ad_oe),
        .rx_ad(s_ad_in),
        .rx_cbe(s_cbe_l_in),
        .rx_par(s_par_in),
        .rx_valid(rx_valid),
        .par_out(s_par_out),
        .par_oe(s_par_oe),
        .par_err(par_err)
    );

endmodule

// ---- sim/spsig_sec_bus_assertions.sv ----
// Concurrent checks on the secondary bus signalling ports
`timescale 1ns/1ps
module spsig_sec_bus_assertions (
    input wire ref_clk, // Clock
    input wire reset, // Reset
    input wire s_gnt_l, // Grant
    input wire [31:0] s_ad_in, // Pin
    input wire [31:0] s_ad_out, // Drive
    input wire s_ad_oe, // Enable
    input wire [3:0] s_cbe_l_in, // Pin
    input wire [3:0] s_cbe_l_out, // Drive
    input wire s_cbe_oe, // Enable
    input wire s_par_in, // Pin
    input wire s_par_out, // Drive
    input wire s_par_oe, // Enable
    input wire s_frame_l_in, // Pin
    input wire s_frame_l_out, // Drive
    input wire s_frame_oe, // Enable
    input wire s_irdy_l_in, // Pin
    input wire s_irdy_l_out, // Drive
    input wire s_irdy_oe, // Enable
    input wire s_trdy_l_in, // Pin
    input wire [3:0] req_cmd, // Command
    input wire req_dual, // Dual
    input wire [31:0] req_addr, // Address
    input wire [31:0] req_addr_hi, // High word
    input wire req_ack, // Taken
    input wire [31:0] dat_wr, // Data
    input wire [3:0] dat_be_l, // Enables
    input wire dat_last, // Last
    input wire dat_ack, // Taken
    input wire xfer_done, // Ended
    input wire busy, // Owned
    input wire tgt_drive, // Bridge drives read data as target
    input wire par_err // Mismatch
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence s_idle_high;
        s_frame_oe && s_frame_l_out && s_irdy_oe && s_irdy_l_out;
    endsequence
    sequence s_released;
        !s_frame_oe && !s_irdy_oe;
    endsequence
    AST_FRAME_IDLE: assert property (xfer_done |-> s_idle_high ##1 s_released)
        else $error("frame or irdy not released after one high cycle");
    AST_PAR_OE: assert property (s_par_oe == $past(s_ad_oe))
        else $error("parity enable does not trail address/data enable");
    AST_PAR_EVEN: assert property (s_par_oe |-> s_par_out == ^{$past(s_ad_out),
        ($past(s_cbe_oe) ? $past(s_cbe_l_out) : $past(s_cbe_l_in))})
        else $error("parity not even over previous bits");
    AST_ADDR: assert property (req_ack |-> s_frame_oe && !s_frame_l_out && s_ad_oe
        && s_ad_out == $past(req_addr) && s_cbe_l_out == ($past(req_dual) ? 4'hd : $past(req_cmd)))
        else $error("address phase wrong");
    AST_DUAL: assert property (req_ack && $past(req_dual) |=> s_ad_out == $past(req_addr_hi, 2)
        && s_cbe_l_out == $past(req_cmd, 2))
        else $error("second address phase wrong");
    AST_DATA: assert property (dat_ack |-> s_irdy_oe && !s_irdy_l_out
        && s_cbe_l_out == $past(dat_be_l) && s_frame_l_out == $past(dat_last)
        && (!s_ad_oe || s_ad_out == $past(dat_wr)))
        else $error("data phase wrong");
    AST_IRDY_HOLD: assert property (s_irdy_oe && !s_irdy_l_out && s_trdy_l_in |=> !s_irdy_l_out)
        else $error("irdy dropped before completion");
    AST_COMPLETE: assert property (s_irdy_oe && !s_irdy_l_out && !s_trdy_l_in |=> s_irdy_l_out)
        else $error("irdy still low after completion");
    AST_PARK: assert property ((!s_gnt_l && !busy && !tgt_drive && s_frame_l_in && s_irdy_l_in)[*3]
        |-> s_ad_oe && s_ad_out == 32'h0 && s_cbe_oe && s_cbe_l_out == 4'h0)
        else $error("idle bus not parked");
    sequence s_rx_phase;
        !s_ad_oe && !s_irdy_l_in && !s_trdy_l_in;
    endsequence
    sequence s_rx_bad;
        s_rx_phase ##1 (s_par_in != ^{$past(s_ad_in), $past(s_cbe_l_in)});
    endsequence
    AST_PERR: assert property (s_rx_bad |=> par_err)
        else $error("bad received parity not flagged");
endmodule

// ---- sim/spsig_tgt_model.sv ----
// Target on the far side of the secondary bus
`timescale 1ns/1ps
module spsig_tgt_model (
    input wire ref_clk, // Clock
    input wire reset, // Reset
    input wire frame_l, // Frame pin
    input wire irdy_l, // Initiator ready pin
    input wire [3:0] cbe_l, // Command/byte enable pins
    input wire slow, // Hold off target ready two cycles
    input wire bad_par, // Send wrong read parity
    input wire [31:0] rdata, // Read data to return
    output reg trdy_l, // Target ready
    output reg [31:0] ad_out, // Read data drive
    output reg ad_oe, // Read data enable
    output reg par_out, // Parity drive
    output reg par_oe // Parity enable
);
    reg frame_q;
    reg dual_q;
    reg is_wr;
    reg [1:0] cnt;
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            trdy_l <= 1'b1;
            ad_oe <= 1'b0;
            par_oe <= 1'b0;
            frame_q <= 1'b1;
            dual_q <= 1'b0;
            is_wr <= 1'b0;
            cnt <= 2'h0;
        end
        else
        begin
            frame_q <= frame_l;
            // Real command follows in the second phase when dual
            if (frame_q && !frame_l)
            begin
                is_wr <= cbe_l[0];
                dual_q <= (cbe_l == 4'hd);
            end
            else if (dual_q)
            begin
                is_wr <= cbe_l[0];
                dual_q <= 1'b0;
            end
            if (!irdy_l && !trdy_l)
            begin
                trdy_l <= 1'b1;
                ad_oe <= 1'b0;
                cnt <= 2'h0;
            end
            else if (!irdy_l)
            begin
                cnt <= cnt + 2'h1;
                if (!slow || cnt == 2'h2)
                begin
                    trdy_l <= 1'b0;
                    ad_oe <= !is_wr;
                    ad_out <= rdata;
                end
            end
            par_oe <= ad_oe;
            par_out <= ^{ad_out, cbe_l} ^ bad_par;
        end
    end
endmodule

// ---- sim/tb_spsig_sec_bus.sv ----
// Testbench of the secondary bus signalling block
`timescale 1ns/1ps
`include "spsig_defines.vh"
module tb_spsig_sec_bus;
    reg ref_clk = 0, reset = 1, s_gnt_l = 0, req_start = 0, req_dual = 0, req_write = 0;
    reg dat_valid = 0, dat_last = 0, tgt_drive = 0, slow = 0, bad_par = 0;
    reg [3:0] req_cmd = 4'h0, dat_be_l = 4'hf;
    reg [31:0] req_addr = 0, req_addr_hi = 0, dat_wr = 0, tgt_data = 0, rdata = 0;
    integer num_errors = 0, samples_checked = 0, perr_n = 0;
    wire [31:0] s_ad_out, rd_data, p_ad;
    wire [3:0] s_cbe_l_out;
    wire s_ad_oe, s_cbe_oe, s_par_out, s_par_oe, s_frame_l_out, s_frame_oe, s_irdy_l_out, s_irdy_oe;
    wire req_ack, dat_ack, rd_valid, xfer_done, busy, par_err, s_trdy_l_in, p_ad_oe, p_par, p_par_oe;
    // Released lines float to the pull-ups
    wire [31:0] s_ad_in = s_ad_oe ? s_ad_out : p_ad_oe ? p_ad : 32'hffffffff;
    wire [3:0] s_cbe_l_in = s_cbe_oe ? s_cbe_l_out : 4'hf;
    wire s_par_in = s_par_oe ? s_par_out : p_par_oe ? p_par : 1'b1;
    wire s_frame_l_in = s_frame_oe ? s_frame_l_out : 1'b1;
    wire s_irdy_l_in = s_irdy_oe ? s_irdy_l_out : 1'b1;
    spsig_sec_bus dut (.*);
    spsig_tgt_model tgt (.ref_clk(ref_clk), .reset(reset), .frame_l(s_frame_l_in), .irdy_l(s_irdy_l_in),
        .cbe_l(s_cbe_l_in), .slow(slow), .bad_par(bad_par), .rdata(rdata), .trdy_l(s_trdy_l_in),
        .ad_out(p_ad), .ad_oe(p_ad_oe), .par_out(p_par), .par_oe(p_par_oe));
    initial
    begin
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
        if (par_err === 1'b1)
            perr_n = perr_n + 1;
    task tick;
        begin
            @(posedge ref_clk);
            #1;
        end
    endtask
    task check(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp)
            begin
                num_errors = num_errors + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task results;
        begin
            $display("errors %0d, checks %0d", num_errors, samples_checked);
            if (num_errors == 0 && samples_checked > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task wait_on(input integer which);
        integer n;
        begin
            n = 0;
            while (n < 40 && (which == 0 ? req_ack : which == 1 ? dat_ack : xfer_done) !== 1'b1)
            begin
                tick;
                n = n + 1;
            end
            if (n == 40)
            begin
                num_errors = num_errors + 1;
                results;
            end
        end
    endtask
    task xact(input [3:0] cmd, input dual, input [31:0] addr, input integer phases, input bad);
        integer i;
        begin
            req_cmd = cmd;
            req_dual = dual;
            req_write = cmd[0];
            req_addr = addr;
            req_addr_hi = ~addr;
            rdata = addr ^ 32'h5a5a0f0f;
            bad_par = bad;
            perr_n = 0;
            req_start = 1;
            wait_on(0);
            check(busy, 1);
            check(s_ad_in, addr);
            check(s_cbe_l_in, dual ? `SPSIG_CMD_DUAL : cmd);
            check(s_frame_l_in, 0);
            tick;
            req_start = 0;
            check(s_par_in, ^{addr, (dual ? `SPSIG_CMD_DUAL : cmd)});
            if (dual)
            begin
                check(s_ad_in, ~addr);
                check(s_cbe_l_in, cmd);
            end
            for (i = 0; i < phases; i = i + 1)
            begin
                dat_wr = addr + i;
                dat_be_l = i[3:0];
                dat_last = (i == phases - 1);
                dat_valid = 1;
                wait_on(1);
                check(s_cbe_l_in, i);
                check(s_frame_l_in, dat_last);
                if (cmd[0])
                    check(s_ad_in, addr + i);
                tick;
                if (cmd[0])
                    check(s_par_in, ^{dat_wr, dat_be_l});
            end
            dat_valid = 0;
            wait_on(2);
            check(rd_valid, !cmd[0]);
            if (!cmd[0])
                check(rd_data, rdata);
            repeat (4) tick;
            check(perr_n, bad);
            check(busy, 0);
        end
    endtask
    // Parked lines, then grant taken away and given back
    task test_park;
        begin
            check(s_ad_in, `SPSIG_PARK_AD);
            check(s_cbe_l_in, `SPSIG_PARK_CBE);
            check(s_par_in, 0);
            s_gnt_l = 1;
            tick;
            check(s_ad_oe | s_cbe_oe, 0);
            tick;
            check(s_par_oe, 0);
            s_gnt_l = 0;
            tick;
            check(s_ad_oe & s_cbe_oe & ~s_par_oe, 1);
            tick;
            check(s_par_oe, 1);
        end
    endtask
    // Bridge as target drives read data; byte enables stay with the pull-ups
    task test_tgt_drive;
        begin
            tgt_data = 32'h13572468;
            tgt_drive = 1;
            tick;
            tick;
            check(s_ad_in, tgt_data);
            check(s_cbe_oe, 0);
            check(s_par_in, ^{tgt_data, 4'hf});
            tgt_drive = 0;
            repeat (4) tick;
            check(s_ad_in, `SPSIG_PARK_AD);
            check(s_par_in, 0);
        end
    endtask
    task test_single_write;
        begin
            xact(4'h7, 0, 32'h12345678, 1, 0);
        end
    endtask
    task test_single_read;
        begin
            xact(4'h6, 0, 32'h000000ff, 1, 0);
        end
    endtask
    task test_dual_slow;
        begin
            slow = 1;
            xact(4'hf, 1, 32'h80000001, 2, 0);
            xact(4'hc, 1, 32'h00000003, 2, 0);
            slow = 0;
        end
    endtask
    task test_read_parity_error;
        begin
            xact(4'h6, 0, 32'hffffffff, 1, 1);
        end
    endtask
    initial
    begin
        repeat (12) @(posedge ref_clk);
        #1;
        check(s_ad_oe | s_frame_oe | s_irdy_oe | s_par_oe, 0);
        reset = 0;
        repeat (4) tick;
        test_park;
        test_tgt_drive;
        test_single_write;
        test_single_read;
        test_dual_slow;
        test_read_parity_error;
        results;
    end
endmodule
bind spsig_sec_bus spsig_sec_bus_assertions chk (.*);
